// file: dv/cpu_program_stack_model_bench.sv
`timescale 1ns/1ps
module cpu_program_stack_model_bench;
  import prog_model_pkg::*;

  logic        clk;
  logic        reset;
  logic        cmd_valid;
  op_e         cmd_op;
  mode_e       cmd_mode;
  logic        cmd_two_byte;
  logic [7:0]  cmd_operand;
  logic [13:0] cmd_target;
  logic        flag_wr;
  logic        flag_carry_in;
  logic        flag_zero_in;
  logic        pullup_supply_pin;
  logic        resonator_in_pin;
  logic        resonator_return_pin;
  logic [2:0]  analog_use;
  logic        cmd_ready;
  logic [13:0] program_counter;
  logic        carry;
  logic        zero;
  logic        int_enable;
  logic [7:0]  accumulator;
  logic [7:0]  index_reg;
  logic [7:0]  call_stack_pointer;
  logic [7:0]  data_stack_pointer;
  logic [2:0]  aux_input;
  int          errors;
  int          checks;
  int          cycles;

  prog_model_core dut_u (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_mode(cmd_mode),
    .cmd_two_byte(cmd_two_byte), .cmd_operand(cmd_operand), .cmd_target(cmd_target),
    .flag_wr(flag_wr), .flag_carry_in(flag_carry_in), .flag_zero_in(flag_zero_in),
    .pullup_supply_pin(pullup_supply_pin), .resonator_in_pin(resonator_in_pin),
    .resonator_return_pin(resonator_return_pin), .analog_use(analog_use), .cmd_ready(cmd_ready),
    .program_counter(program_counter), .carry(carry), .zero(zero), .int_enable(int_enable),
    .accumulator(accumulator), .index_reg(index_reg), .call_stack_pointer(call_stack_pointer),
    .data_stack_pointer(data_stack_pointer), .aux_input(aux_input)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic do_reset();
    @(negedge clk);
    reset = 1'b1;
    cmd_valid = 1'b0;
    flag_wr = 1'b0;
    cmd_two_byte = 1'b0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
  endtask : do_reset

  // Held through the taking edge, then wait on the ready handshake
  task automatic issue(input op_e op, input mode_e md, input logic [7:0] opnd, input logic [13:0] tgt);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_mode = md;
    cmd_operand = opnd;
    cmd_target = tgt;
    @(negedge clk);
    cmd_valid = 1'b0;
    // Let an edge pass so valid never drops and rises in one step
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(16'(cmd_ready), 16'h0001, "ready after command");
  endtask : issue

  task automatic set_flags(input logic c, input logic z);
    flag_wr = 1'b1;
    flag_carry_in = c;
    flag_zero_in = z;
    @(negedge clk);
    flag_wr = 1'b0;
  endtask : set_flags

  task automatic ld_dir(input logic [7:0] a);
    issue(OP_LOAD_A, MODE_DIRECT, a, 14'h0000);
  endtask : ld_dir

  task automatic t_reset();
    do_reset();
    chk(16'(program_counter), 16'h0000, "pc after reset");
    chk(16'(call_stack_pointer), 16'h0000, "csp after reset");
    chk(16'(data_stack_pointer), 16'h0000, "dsp after reset");
    chk({accumulator, index_reg}, 16'h0000, "acc and x after reset");
    chk({13'h0000, carry, zero, int_enable}, 16'h0000, "flags after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_counter();
    do_reset();
    issue(OP_CALL, MODE_IMMEDIATE, 8'h00, 14'h01FE);
    cmd_two_byte = 1'b1;
    issue(OP_STEP, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(program_counter), 16'h0100, "two byte step wraps low byte");
    cmd_two_byte = 1'b0;
    issue(OP_STEP, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(program_counter), 16'h0101, "one byte step");
    issue(OP_CALL, MODE_IMMEDIATE, 8'h00, 14'h02FF);
    issue(OP_PAGE, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(program_counter), 16'h0300, "page advance");
    $display("test counter done");
  endtask : t_counter

  task automatic t_call_ret();
    do_reset();
    set_flags(1'b1, 1'b0);
    issue(OP_CALL, MODE_IMMEDIATE, 8'h00, 14'h12FF);
    issue(OP_CALL, MODE_IMMEDIATE, 8'h00, 14'h0456);
    chk(16'(program_counter), 16'h0456, "call target");
    chk(16'(call_stack_pointer), 16'h0004, "csp after two calls");
    ld_dir(8'h02);
    chk(16'(accumulator), 16'h0001, "saved low byte in ram");
    ld_dir(8'h03);
    chk(16'(accumulator), 16'h0092, "saved flags and page in ram");
    set_flags(1'b0, 1'b1);
    issue(OP_RET, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(program_counter), 16'h1201, "return address");
    chk(16'(call_stack_pointer), 16'h0002, "csp after return");
    chk({14'h0000, carry, zero}, 16'h0001, "flags kept by return");
    $display("test call return done");
  endtask : t_call_ret

  task automatic t_interrupt();
    do_reset();
    issue(OP_EI, MODE_IMMEDIATE, 8'h00, 14'h0000);
    issue(OP_CALL, MODE_IMMEDIATE, 8'h00, 14'h0234);
    set_flags(1'b1, 1'b1);
    issue(OP_INT_ACK, MODE_IMMEDIATE, 8'h00, 14'h0010);
    chk({15'h0000, int_enable}, 16'h0000, "entry disables interrupts");
    chk(16'(call_stack_pointer), 16'h0004, "csp after entry");
    chk(16'(program_counter), 16'h0010, "vector taken");
    ld_dir(8'h02);
    chk(16'(accumulator), 16'h0034, "first saved byte");
    ld_dir(8'h03);
    chk(16'(accumulator), 16'h00C2, "second saved byte");
    set_flags(1'b0, 1'b0);
    issue(OP_INTERRUPT_EXIT_INSTRUCTION, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(program_counter), 16'h0234, "pc restored");
    chk({13'h0000, carry, zero, int_enable}, 16'h0007, "flags restored, enabled");
    chk(16'(call_stack_pointer), 16'h0002, "csp after exit");
    $display("test interrupt done");
  endtask : t_interrupt

  task automatic t_stack_base();
    do_reset();
    issue(OP_LOAD_A, MODE_IMMEDIATE, 8'hFE, 14'h0000);
    chk(16'(accumulator), 16'h00FE, "immediate load");
    issue(OP_STACK_BASE, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(call_stack_pointer), 16'h00FE, "stack base load");
    issue(OP_CALL, MODE_IMMEDIATE, 8'h00, 14'h0100);
    chk(16'(call_stack_pointer), 16'h0000, "csp wraps");
    ld_dir(8'hFE);
    chk(16'(accumulator), 16'h0002, "frame at top of ram");
    issue(OP_RET, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(call_stack_pointer), 16'h00FE, "csp wraps back");
    chk(16'(program_counter), 16'h0002, "return after wrap");
    $display("test stack base done");
  endtask : t_stack_base

  task automatic t_data_stack();
    do_reset();
    issue(OP_LOAD_A, MODE_IMMEDIATE, 8'h5A, 14'h0000);
    issue(OP_PUSH_A, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(data_stack_pointer), 16'h00FF, "push predecrements");
    issue(OP_LOAD_A, MODE_IMMEDIATE, 8'h00, 14'h0000);
    ld_dir(8'hFF);
    chk(16'(accumulator), 16'h005A, "push from zero hits top");
    issue(OP_LOAD_X, MODE_IMMEDIATE, 8'h3C, 14'h0000);
    issue(OP_PUSH_X, MODE_IMMEDIATE, 8'h00, 14'h0000);
    issue(OP_POP_A, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk({accumulator, data_stack_pointer}, 16'h3CFF, "pop then increment");
    issue(OP_POP_X, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk({index_reg, data_stack_pointer}, 16'h5A00, "pop wraps to zero");
    $display("test data stack done");
  endtask : t_data_stack

  task automatic t_modes();
    do_reset();
    issue(OP_LOAD_A, MODE_IMMEDIATE, 8'h77, 14'h0000);
    issue(OP_STORE_A, MODE_DIRECT, 8'h13, 14'h0000);
    issue(OP_LOAD_X, MODE_IMMEDIATE, 8'h03, 14'h0000);
    issue(OP_LOAD_A, MODE_IMMEDIATE, 8'h00, 14'h0000);
    issue(OP_LOAD_A, MODE_INDEXED, 8'h10, 14'h0000);
    chk(16'(accumulator), 16'h0077, "indexed read base plus x");
    issue(OP_STORE_A, MODE_INDEXED, 8'h20, 14'h0000);
    issue(OP_LOAD_A, MODE_IMMEDIATE, 8'h00, 14'h0000);
    ld_dir(8'h23);
    chk(16'(accumulator), 16'h0077, "indexed write then direct read");
    $display("test address modes done");
  endtask : t_modes

  task automatic t_aux();
    analog_use = 3'b000;
    pullup_supply_pin = 1'b1;
    resonator_in_pin = 1'b0;
    resonator_return_pin = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(aux_input), 16'h0005, "aux pattern one");
    issue(OP_AUX_READ, MODE_IMMEDIATE, 8'h00, 14'h0000);
    chk(16'(accumulator), 16'h0005, "aux read into accumulator");
    pullup_supply_pin = 1'b0;
    resonator_in_pin = 1'b1;
    resonator_return_pin = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(aux_input), 16'h0002, "aux pattern two");
    analog_use = 3'b010;
    repeat (2) @(negedge clk);
    chk(16'(aux_input), 16'h0000, "analog use masks bit");
    $display("test aux inputs done");
  endtask : t_aux

  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_STEP;
    cmd_mode = MODE_IMMEDIATE;
    cmd_two_byte = 1'b0;
    cmd_operand = 8'h00;
    cmd_target = 14'h0000;
    flag_wr = 1'b0;
    flag_carry_in = 1'b0;
    flag_zero_in = 1'b0;
    pullup_supply_pin = 1'b0;
    resonator_in_pin = 1'b0;
    resonator_return_pin = 1'b0;
    analog_use = 3'b000;
    t_reset();
    t_counter();
    t_call_ret();
    t_interrupt();
    t_stack_base();
    t_data_stack();
    t_modes();
    t_aux();
    close_out();
  end

endmodule : cpu_program_stack_model_bench

// file: hw/aux_input_port.sv
`timescale 1ns/1ps
module aux_input_port (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            pullup_supply_pin,
  input  wire logic                            resonator_in_pin,
  input  wire logic                            resonator_return_pin,
  input  wire logic [prog_model_pkg::AUX_W-1:0] analog_use,
  output      logic [prog_model_pkg::AUX_W-1:0] aux_bits
);
  import prog_model_pkg::*;

  logic [AUX_W-1:0] raw;

  assign raw[AUX_PULLUP]  = pullup_supply_pin;
  assign raw[AUX_RES_IN]  = resonator_in_pin;
  assign raw[AUX_RES_RET] = resonator_return_pin;

  // Pins in analog use read as zero
  always_ff @(posedge clk) begin
    if (reset) begin
      aux_bits <= '0;
    end else begin
      aux_bits <= raw & ~analog_use;
    end
  end
endmodule : aux_input_port

// file: hw/data_ram.sv
`timescale 1ns/1ps
module data_ram (
  input wire logic clk,
  ram_port_if.mem  port
);
  import prog_model_pkg::*;

  logic [7:0] mem_r [RAM_DEPTH];

  // Asynchronous read so a pop or reload completes in its own cycle
  assign port.rdata = mem_r[port.addr];

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
  end
endmodule : data_ram

// file: hw/prog_model_core.sv
// Behaviour
// - 14-bit counter, reset fetches from zero
// - Sequential advance touches low byte only
// - Page advance increments upper six bits and low byte
// - Call and interrupt save two bytes
// - Only interrupt exit restores flags
// - Counter hidden; saved bytes in RAM
// - Reset clears call stack pointer
// - Stack base load copies accumulator
// - Interrupt entry: disable, write, increment twice
// - Interrupt exit: decrement, reload twice, enable
// - Call advances call stack by two
// - Subroutine exit restores counter, keeps flags
// - Push predecrements then writes
// - Pop reads then postincrements
// - Reset clears data pointer; push hits 0xFF
// - Immediate operand from second byte
// - Direct operand read from RAM address
// - Indexed address is constant plus index
// - Aux bits read three multiplexed pins
// - Registers are eight bits wide
`timescale 1ns/1ps
module prog_model_core (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      cmd_valid,
  input  wire prog_model_pkg::op_e       cmd_op,
  input  wire prog_model_pkg::mode_e     cmd_mode,
  input  wire logic                      cmd_two_byte,
  input  wire logic [7:0]                cmd_operand,
  input  wire logic [13:0]               cmd_target,
  input  wire logic                      flag_wr,
  input  wire logic                      flag_carry_in,
  input  wire logic                      flag_zero_in,
  input  wire logic                      pullup_supply_pin,
  input  wire logic                      resonator_in_pin,
  input  wire logic                      resonator_return_pin,
  input  wire logic [2:0]                analog_use,
  output      logic                      cmd_ready,
  output      logic [13:0]               program_counter,
  output      logic                      carry,
  output      logic                      zero,
  output      logic                      int_enable,
  output      logic [7:0]                accumulator,
  output      logic [7:0]                index_reg,
  output      logic [7:0]                call_stack_pointer,
  output      logic [7:0]                data_stack_pointer,
  output      logic [2:0]                aux_input
);
  import prog_model_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAVE_FIRST,
    ST_SAVE_SECOND,
    ST_LOAD_SECOND,
    ST_LOAD_FIRST,
    ST_PUSH_WRITE,
    ST_POP_READ,
    ST_OPERAND
  } state_e;

  state_e      state_r;
  state_e      state_nxt;
  logic [13:0] ret_addr_r;
  logic [13:0] target_r;
  logic [7:0]  hold_r;
  logic [7:0]  ea_r;
  logic        to_x_r;
  logic        is_store_r;
  logic        is_interrupt_exit_instruction_r;
  logic        accept;
  logic [7:0]  push_value;
  logic [7:0]  save_high;
  logic [7:0]  eff_addr;
  logic [13:0] call_ret;
  logic [13:0] restore_pc;

  ram_port_if ram ();

  data_ram u_ram (
    .clk  (clk),
    .port (ram.mem)
  );

  // Aux pins sampled one cycle then presented
  // aux pin mux
  aux_input_port u_aux (
    .clk                  (clk),
    .reset                (reset),
    .pullup_supply_pin    (pullup_supply_pin),
    .resonator_in_pin     (resonator_in_pin),
    .resonator_return_pin (resonator_return_pin),
    .analog_use           (analog_use),
    .aux_bits             (aux_input)
  );

  assign accept     = cmd_valid && cmd_ready;
  assign push_value = (cmd_op == OP_PUSH_X) ? index_reg : accumulator;
  assign save_high  = {carry, zero, ret_addr_r[13:8]};
  assign eff_addr   = (cmd_mode == MODE_INDEXED) ? 8'(cmd_operand + index_reg) : cmd_operand;
  assign call_ret   = step_low(program_counter, CALL_LEN);
  assign restore_pc = {hold_r[5:0], ram.rdata};

  // RAM address and write steering per state
  // frames visible as RAM
  assign ram.addr  = (state_r == ST_SAVE_FIRST || state_r == ST_SAVE_SECOND ||
                      state_r == ST_LOAD_SECOND || state_r == ST_LOAD_FIRST) ? call_stack_pointer :
                     (state_r == ST_PUSH_WRITE || state_r == ST_POP_READ) ? data_stack_pointer : ea_r;
  assign ram.we    = (state_r == ST_SAVE_FIRST) || (state_r == ST_SAVE_SECOND) ||
                     (state_r == ST_PUSH_WRITE) || (state_r == ST_OPERAND && is_store_r);
  assign ram.wdata = (state_r == ST_SAVE_FIRST)  ? ret_addr_r[7:0] :
                     (state_r == ST_SAVE_SECOND) ? save_high : hold_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          unique case (cmd_op)
            OP_CALL, OP_INT_ACK:  state_nxt = ST_SAVE_FIRST;
            OP_RET, OP_INTERRUPT_EXIT_INSTRUCTION:      state_nxt = ST_LOAD_SECOND;
            OP_PUSH_A, OP_PUSH_X: state_nxt = ST_PUSH_WRITE;
            OP_POP_A, OP_POP_X:   state_nxt = ST_POP_READ;
            OP_LOAD_A, OP_LOAD_X: state_nxt = (cmd_mode == MODE_IMMEDIATE) ? ST_IDLE : ST_OPERAND;
            OP_STORE_A:           state_nxt = ST_OPERAND;
            default:              state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_SAVE_FIRST:  state_nxt = ST_SAVE_SECOND;
      ST_LOAD_SECOND: state_nxt = ST_LOAD_FIRST;
      default:        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      cmd_ready <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      cmd_ready <= (state_nxt == ST_IDLE);
    end
  end

  // Program counter and interrupt enable
  always_ff @(posedge clk) begin
    if (reset) begin
      program_counter <= PC_RESET;
      int_enable      <= 1'b0;
      ret_addr_r      <= PC_RESET;
      target_r        <= PC_RESET;
      is_interrupt_exit_instruction_r       <= 1'b0;
    end else if (state_r == ST_IDLE && accept) begin
      unique case (cmd_op)
        OP_STEP: program_counter <= step_low(program_counter, cmd_two_byte ? 8'h02 : 8'h01);
        OP_PAGE: program_counter <= {program_counter[13:8] + PAGE_STEP, program_counter[7:0] + PTR_STEP};
        OP_CALL: begin
          ret_addr_r <= call_ret;
          target_r   <= cmd_target;
        end
        OP_INT_ACK: begin
          int_enable <= 1'b0;
          ret_addr_r <= program_counter;
          target_r   <= cmd_target;
        end
        OP_RET:  is_interrupt_exit_instruction_r <= 1'b0;
        OP_INTERRUPT_EXIT_INSTRUCTION: is_interrupt_exit_instruction_r <= 1'b1;
        OP_EI:   int_enable <= 1'b1;
        default: ;
      endcase
    end else if (state_r == ST_SAVE_SECOND) begin
      program_counter <= target_r;
    end else if (state_r == ST_LOAD_FIRST) begin
      program_counter <= restore_pc;
      if (is_interrupt_exit_instruction_r) begin
        int_enable <= 1'b1;
      end
    end
  end

  // Flags change only by the ALU side or by interrupt exit
  always_ff @(posedge clk) begin
    if (reset) begin
      carry <= 1'b0;
      zero  <= 1'b0;
    end else if (state_r == ST_LOAD_FIRST && is_interrupt_exit_instruction_r) begin
      carry <= hold_r[SAVE_CARRY];
      zero  <= hold_r[SAVE_ZERO];
    end else if (flag_wr) begin
      carry <= flag_carry_in;
      zero  <= flag_zero_in;
    end
  end

  // Call stack pointer, wraps modulo 256
  always_ff @(posedge clk) begin
    if (reset) begin
      call_stack_pointer <= CSP_RESET;
    end else if (state_r == ST_IDLE && accept && cmd_op == OP_STACK_BASE) begin
      call_stack_pointer <= accumulator;
    end else if (state_r == ST_IDLE && accept && (cmd_op == OP_RET || cmd_op == OP_INTERRUPT_EXIT_INSTRUCTION)) begin
      call_stack_pointer <= ptr_dec(call_stack_pointer);
    end else if (state_r == ST_LOAD_SECOND) begin
      call_stack_pointer <= ptr_dec(call_stack_pointer);
    end else if (state_r == ST_SAVE_FIRST || state_r == ST_SAVE_SECOND) begin
      call_stack_pointer <= ptr_inc(call_stack_pointer);
    end
  end

  // Data stack pointer and working registers
  // eight-bit registers
  always_ff @(posedge clk) begin
    if (reset) begin
      data_stack_pointer <= DSP_RESET;
      accumulator        <= BYTE_RESET;
      index_reg          <= BYTE_RESET;
      hold_r             <= BYTE_RESET;
      ea_r               <= BYTE_RESET;
      to_x_r             <= 1'b0;
      is_store_r         <= 1'b0;
    end else if (state_r == ST_IDLE && accept) begin
      to_x_r     <= (cmd_op == OP_POP_X) || (cmd_op == OP_LOAD_X);
      is_store_r <= (cmd_op == OP_STORE_A);
      ea_r       <= eff_addr;
      unique case (cmd_op)
        OP_PUSH_A, OP_PUSH_X: begin
          data_stack_pointer <= ptr_dec(data_stack_pointer);
          hold_r             <= push_value;
        end
        OP_STORE_A:  hold_r <= accumulator;
        OP_LOAD_A:   if (cmd_mode == MODE_IMMEDIATE) accumulator <= cmd_operand;
        OP_LOAD_X:   if (cmd_mode == MODE_IMMEDIATE) index_reg <= cmd_operand;
        OP_AUX_READ: accumulator <= {5'h00, aux_input};
        default: ;
      endcase
    end else if (state_r == ST_LOAD_SECOND) begin
      hold_r <= ram.rdata;
    end else if (state_r == ST_POP_READ || (state_r == ST_OPERAND && !is_store_r)) begin
      if (to_x_r) begin
        index_reg <= ram.rdata;
      end else begin
        accumulator <= ram.rdata;
      end
      if (state_r == ST_POP_READ) begin
        data_stack_pointer <= ptr_inc(data_stack_pointer);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_RESET_CLEAR: assert property ($past(reset) |->
    program_counter == PC_RESET && call_stack_pointer == CSP_RESET && data_stack_pointer == DSP_RESET)
    else $error("state not cleared after reset");
  AST_STEP_LOW: assert property (accept && cmd_op == OP_STEP |=>
    program_counter[13:8] == $past(program_counter[13:8]))
    else $error("sequential step changed page");
  AST_PAGE_ADV: assert property (accept && cmd_op == OP_PAGE |=>
    program_counter[13:8] == 6'($past(program_counter[13:8]) + PAGE_STEP))
    else $error("page advance wrong");
  AST_CALL_TWO: assert property (accept && cmd_op == OP_CALL |-> ##3
    call_stack_pointer == 8'($past(call_stack_pointer, 3) + CALL_LEN) && program_counter == $past(cmd_target, 3))
    else $error("call did not advance stack by two");
  AST_INT_OFF: assert property (accept && cmd_op == OP_INT_ACK |=>
    !int_enable && ram.we && ram.addr == $past(call_stack_pointer) ##1
    ram.we && ram.addr == 8'($past(call_stack_pointer, 2) + PTR_STEP))
    else $error("interrupt entry order wrong");
  AST_RET_FLAGS: assert property (accept && cmd_op == OP_RET && !flag_wr ##1 !flag_wr[*2] |=>
    carry == $past(carry, 3) && call_stack_pointer == 8'($past(call_stack_pointer, 3) - CALL_LEN))
    else $error("subroutine exit touched flags");
  AST_INTERRUPT_EXIT_INSTRUCTION_ENABLE: assert property (accept && cmd_op == OP_INTERRUPT_EXIT_INSTRUCTION |-> ##3 int_enable)
    else $error("interrupt exit did not enable");
  AST_PUSH_ADDR: assert property (accept && (cmd_op == OP_PUSH_A || cmd_op == OP_PUSH_X) |=>
    ram.we && ram.addr == 8'($past(data_stack_pointer) - PTR_STEP))
    else $error("push address not predecremented");
  AST_POP_INC: assert property (accept && cmd_op == OP_POP_A |-> ##2
    data_stack_pointer == 8'($past(data_stack_pointer, 2) + PTR_STEP))
    else $error("pop did not postincrement");
  AST_INDEXED: assert property (accept && cmd_op == OP_LOAD_A && cmd_mode == MODE_INDEXED |=>
    ram.addr == 8'($past(cmd_operand) + $past(index_reg)))
    else $error("indexed address wrong");

  COV_CALL_RET: cover property (accept && cmd_op == OP_CALL ##[3:20] accept && cmd_op == OP_RET);
  COV_INT_INTERRUPT_EXIT_INSTRUCTION: cover property (accept && cmd_op == OP_INT_ACK ##[3:20] accept && cmd_op == OP_INTERRUPT_EXIT_INSTRUCTION);
  COV_PUSH_ZERO: cover property (accept && cmd_op == OP_PUSH_A && data_stack_pointer == DSP_RESET);
endmodule : prog_model_core

// file: hw/prog_model_pkg.sv
package prog_model_pkg;

  localparam int          PC_W        = 14;
  localparam int          LOW_W       = 8;
  localparam int          HIGH_W      = 6;
  localparam int          DATA_W      = 8;
  localparam int          RAM_DEPTH   = 256;
  localparam logic [13:0] PC_RESET    = 14'h0000;
  localparam logic [7:0]  CSP_RESET   = 8'h00;
  localparam logic [7:0]  DSP_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [7:0]  PTR_STEP    = 8'h01;
  localparam logic [5:0]  PAGE_STEP   = 6'h01;
  localparam logic [7:0]  CALL_LEN    = 8'h02;
  localparam int          AUX_W       = 3;
  localparam int          AUX_PULLUP  = 0;
  localparam int          AUX_RES_IN  = 1;
  localparam int          AUX_RES_RET = 2;
  localparam int          SAVE_CARRY  = 7;
  localparam int          SAVE_ZERO   = 6;

  typedef enum logic [3:0] {
    OP_STEP,
    OP_PAGE,
    OP_CALL,
    OP_RET,
    OP_INTERRUPT_EXIT_INSTRUCTION,
    OP_INT_ACK,
    OP_STACK_BASE,
    OP_PUSH_A,
    OP_PUSH_X,
    OP_POP_A,
    OP_POP_X,
    OP_LOAD_A,
    OP_LOAD_X,
    OP_STORE_A,
    OP_AUX_READ,
    OP_EI
  } op_e;

  typedef enum logic [1:0] {
    MODE_IMMEDIATE,
    MODE_DIRECT,
    MODE_INDEXED
  } mode_e;

  // Low byte wraps inside the page, upper bits never carry
  function automatic logic [13:0] step_low(input logic [13:0] pc, input logic [7:0] len);
    logic [7:0] lo;
    lo = pc[7:0] + len;
    return {pc[13:8], lo};
  endfunction : step_low

  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    return p + PTR_STEP;
  endfunction : ptr_inc

  function automatic logic [7:0] ptr_dec(input logic [7:0] p);
    return p - PTR_STEP;
  endfunction : ptr_dec

endpackage : prog_model_pkg

// file: hw/ram_port_if.sv
`timescale 1ns/1ps
interface ram_port_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface : ram_port_if
